// ---- pport_control.sv ----
// control, configuration, pin mapping and register file of the parallel port
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pport_defines.svh"

module pport_control #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // device power state
  input  wire logic              idleMode,
  // data lines
  input  wire logic [7:0]        dataIn,
  output var  logic [7:0]        dataOut,
  output var  logic              dataOe,
  // address and select lines
  output var  logic [15:0]       addrOut,
  output var  logic [15:0]       addrOe,
  input  wire logic              selectOneIn,
  // strobes
  input  wire logic              readStrobeIn,
  output var  logic              readStrobeOut,
  output var  logic              readStrobeOe,
  input  wire logic              writeStrobeIn,
  output var  logic              writeStrobeOut,
  output var  logic              writeStrobeOe,
  output var  logic              byteEnableOut,
  output var  logic              byteEnableOe
);

  // the register decoder needs a full byte of offset
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("pport_control: ADDR_W must be at least 8");
  end

  pport_pkg::pport_state_t s;
  pport_pkg::pport_state_t next_s;

  // pin level from an assertion and its polarity bit (set = active high)
  function automatic logic pinLevel(input logic active, input logic pol);
    pinLevel = active ? pol : ~pol;
  endfunction : pinLevel

  logic        enabled;
  logic        halted;
  logic        master;
  logic        modeOne;
  logic [1:0]  muxSel;
  logic [1:0]  selFunc;
  logic        access;
  logic        done;
  logic        hit;
  logic        busy;
  logic        startOk;
  logic        slaveWr;
  logic        slaveRd;
  logic        xferOn;
  logic        strobeOn;
  logic        latchLow;
  logic        latchHigh;
  logic [15:0] rdMux;
  logic [15:0] newCtl;
  pport_pkg::pport_phase_t firstPhase;

  always_comb begin
    next_s   = s;
    enabled  = s.regs.control[`PP_CTL_ENABLE];
    halted   = s.regs.control[`PP_CTL_IDLE_STOP] & idleMode;
    master   = s.regs.mode[`PP_MODE_SEL_HI];
    modeOne  = s.regs.mode[`PP_MODE_SEL_HI:`PP_MODE_SEL_LO] == `PP_PM_MASTER1;
    muxSel   = s.regs.control[`PP_CTL_MUX_HI:`PP_CTL_MUX_LO];
    selFunc  = s.regs.control[`PP_CTL_SEL_HI:`PP_CTL_SEL_LO];
    busy     = s.phase != pport_pkg::PP_IDLE;
    startOk  = enabled & master & ~busy & ~halted;
    newCtl   = pwdata[15:0] & `PP_CTL_MASK;
    // reserved mux code 11 behaves as separate pins
    firstPhase = (muxSel == 2'h1 || muxSel == `PP_MUX_FULL) ?
                 pport_pkg::PP_ADDRL : pport_pkg::PP_STRB;

    // slave strobes, qualified by the first select input
    slaveWr = (writeStrobeIn == s.regs.control[`PP_CTL_WR_POL]) &
              (selectOneIn == s.regs.control[`PP_CTL_SEL1_POL]);
    slaveRd = (readStrobeIn == s.regs.control[`PP_CTL_RD_POL]) &
              (selectOneIn == s.regs.control[`PP_CTL_SEL1_POL]);

    // register read mux
    hit   = 1'b1;
    rdMux = 16'h0000;
    unique case (paddr[7:0])
      `PP_OFF_CONTROL:   rdMux = s.regs.control & `PP_CTL_MASK;
      `PP_OFF_MODE:      rdMux = {busy, s.regs.mode[14:0]};
      `PP_OFF_ADDRESS:   rdMux = s.regs.address;
      `PP_OFF_OUT_TWO:   rdMux = s.regs.outTwo;
      `PP_OFF_IN_ONE:    rdMux = s.regs.inOne;
      `PP_OFF_IN_TWO:    rdMux = s.regs.inTwo;
      `PP_OFF_PIN_ALLOC: rdMux = s.regs.pinAlloc;
      `PP_OFF_STATUS:    rdMux = s.regs.status & 16'hcfcf;
      default: begin
        hit   = 1'b0;
        rdMux = 16'h0000;
      end
    endcase
    if ((paddr >> 8) != '0) begin
      hit = 1'b0;
    end

    // apb: one wait cycle so read data comes from a flip-flop
    access        = psel & penable;
    done          = access & s.pready;
    next_s.pready = access & ~s.pready;
    next_s.pslverr = access & ~s.pready & ~hit;
    if (access & ~s.pready) begin
      next_s.prdata = hit ? {16'h0000, rdMux} : 32'h0000_0000;
    end

    // master transfer sequencer; frozen while halted in idle
    if (enabled & ~halted) begin
      unique case (s.phase)
        pport_pkg::PP_IDLE: begin
        end
        pport_pkg::PP_ADDRL: begin
          next_s.phase = (muxSel == `PP_MUX_FULL) ? pport_pkg::PP_ADDRH
                                                  : pport_pkg::PP_STRB;
        end
        pport_pkg::PP_ADDRH: begin
          next_s.phase = pport_pkg::PP_STRB;
        end
        pport_pkg::PP_STRB: begin
          if (s.isRead) begin
            next_s.regs.inOne = {s.regs.inOne[15:8], dataIn};
          end
          next_s.phase = pport_pkg::PP_HOLD;
        end
        pport_pkg::PP_HOLD: begin
          next_s.phase = pport_pkg::PP_IDLE;
        end
        default: begin
          next_s.phase = pport_pkg::PP_IDLE;
        end
      endcase
    end

    // software side of the register file
    if (done & hit & pwrite) begin
      unique case (paddr[7:0])
        `PP_OFF_CONTROL: begin
          next_s.regs.control = newCtl;
          if (newCtl[`PP_CTL_ENABLE] & ~enabled) begin
            next_s.regs.status = `PP_ST_RESET;
            next_s.slaveWrPrev = 1'b0;
            next_s.slaveRdPrev = 1'b0;
          end
        end
        `PP_OFF_MODE:      next_s.regs.mode = pwdata[15:0] & `PP_MODE_MASK;
        `PP_OFF_ADDRESS: begin
          next_s.regs.address = pwdata[15:0];
          if (~master) begin
            next_s.regs.status[`PP_ST_OUT_EMPTY]  = 1'b0;
            next_s.regs.status[`PP_ST_OUT0_EMPTY] = 1'b0;
          end
        end
        `PP_OFF_OUT_TWO:   next_s.regs.outTwo   = pwdata[15:0];
        `PP_OFF_PIN_ALLOC: next_s.regs.pinAlloc = pwdata[15:0];
        `PP_OFF_IN_ONE: begin
          next_s.regs.inOne = pwdata[15:0];
          if (startOk) begin
            next_s.phase  = firstPhase;
            next_s.isRead = 1'b0;
          end
        end
        `PP_OFF_STATUS: begin
          next_s.regs.status[`PP_ST_IN_OVF]  = pwdata[`PP_ST_IN_OVF];
          next_s.regs.status[`PP_ST_OUT_UNF] = pwdata[`PP_ST_OUT_UNF];
        end
        default: begin
        end
      endcase
    end

    // reading the first input register starts a master read or frees a slave byte
    if (done & hit & ~pwrite && paddr[7:0] == `PP_OFF_IN_ONE) begin
      if (startOk) begin
        next_s.phase  = firstPhase;
        next_s.isRead = 1'b1;
      end else if (~master) begin
        next_s.regs.status[`PP_ST_IN_FULL]  = 1'b0;
        next_s.regs.status[`PP_ST_IN0_FULL] = 1'b0;
      end
    end

    // disable stops everything in flight but keeps the registers
    if (~next_s.regs.control[`PP_CTL_ENABLE]) begin
      next_s.phase = pport_pkg::PP_IDLE;
    end

    // slave strobe tracking; hardware sets come last so they beat clears
    if (enabled & ~master & ~halted) begin
      next_s.slaveWrPrev = slaveWr;
      next_s.slaveRdPrev = slaveRd;
      if (slaveWr & ~s.regs.status[`PP_ST_IN_FULL]) begin
        next_s.regs.inOne = {s.regs.inOne[15:8], dataIn};
      end
      if (s.slaveWrPrev & ~slaveWr) begin
        if (s.regs.status[`PP_ST_IN_FULL]) begin
          next_s.regs.status[`PP_ST_IN_OVF] = 1'b1;
        end else begin
          next_s.regs.status[`PP_ST_IN_FULL]  = 1'b1;
          next_s.regs.status[`PP_ST_IN0_FULL] = 1'b1;
        end
      end
      if (s.slaveRdPrev & ~slaveRd) begin
        if (s.regs.status[`PP_ST_OUT_EMPTY]) begin
          next_s.regs.status[`PP_ST_OUT_UNF] = 1'b1;
        end else begin
          next_s.regs.status[`PP_ST_OUT_EMPTY]  = 1'b1;
          next_s.regs.status[`PP_ST_OUT0_EMPTY] = 1'b1;
        end
      end
    end

    // pins follow the next phase so they change on the same edge
    xferOn    = next_s.phase != pport_pkg::PP_IDLE;
    strobeOn  = next_s.phase == pport_pkg::PP_STRB;
    latchLow  = next_s.phase == pport_pkg::PP_ADDRL;
    latchHigh = (muxSel == `PP_MUX_FULL) && next_s.phase == pport_pkg::PP_ADDRH;

    next_s.pins.addrOut = s.regs.address;
    if (selFunc == `PP_SEL_BOTH) begin
      next_s.pins.addrOut[14] = pinLevel(xferOn & s.regs.address[14],
                                         s.regs.control[`PP_CTL_SEL1_POL]);
    end
    if (selFunc == `PP_SEL_BOTH || selFunc == `PP_SEL_TWO) begin
      next_s.pins.addrOut[15] = pinLevel(xferOn & s.regs.address[15],
                                         s.regs.control[`PP_CTL_SEL2_POL]);
    end
    if (muxSel == 2'h1 || muxSel == `PP_MUX_FULL) begin
      next_s.pins.addrOut[0] = pinLevel(latchLow, s.regs.control[`PP_CTL_LATCH_POL]);
      next_s.pins.addrOut[1] = pinLevel(latchHigh, s.regs.control[`PP_CTL_LATCH_POL]);
    end
    next_s.pins.addrOe = (enabled & master) ? s.regs.pinAlloc : 16'h0000;

    if (modeOne) begin
      next_s.pins.readStrobeOut  = pinLevel(xferOn & next_s.isRead,
                                            s.regs.control[`PP_CTL_RD_POL]);
      next_s.pins.writeStrobeOut = pinLevel(strobeOn, s.regs.control[`PP_CTL_WR_POL]);
    end else begin
      next_s.pins.readStrobeOut  = pinLevel(strobeOn & next_s.isRead,
                                            s.regs.control[`PP_CTL_RD_POL]);
      next_s.pins.writeStrobeOut = pinLevel(strobeOn & ~next_s.isRead,
                                            s.regs.control[`PP_CTL_WR_POL]);
    end
    next_s.pins.readStrobeOe  = enabled & master & s.regs.control[`PP_CTL_RD_PIN_EN];
    next_s.pins.writeStrobeOe = enabled & master & s.regs.control[`PP_CTL_WR_PIN_EN];
    next_s.pins.byteEnableOut = pinLevel(xferOn & s.regs.mode[`PP_MODE_WIDE],
                                         s.regs.control[`PP_CTL_BE_POL]);
    next_s.pins.byteEnableOe  = enabled & master & s.regs.control[`PP_CTL_BE_PIN_EN];

    // data lines: address phases, then write data from its next value, so a write shows
    // the byte stored on its own starting edge; slave drives its out buffer as registered
    next_s.pins.dataOut = next_s.regs.inOne[7:0];
    next_s.pins.dataOe  = 1'b0;
    if (enabled & master) begin
      if (latchLow) begin
        next_s.pins.dataOut = s.regs.address[7:0];
        next_s.pins.dataOe  = 1'b1;
      end else if (next_s.phase == pport_pkg::PP_ADDRH) begin
        next_s.pins.dataOut = s.regs.address[15:8];
        next_s.pins.dataOe  = 1'b1;
      end else if (xferOn & ~next_s.isRead) begin
        next_s.pins.dataOut = next_s.regs.inOne[7:0];
        next_s.pins.dataOe  = 1'b1;
      end
    end else if (enabled & slaveRd) begin
      next_s.pins.dataOut = s.regs.address[7:0];
      next_s.pins.dataOe  = 1'b1;
    end
  end

  // all state resets to constants; status empties read as set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s             <= '0;
      s.regs.status <= `PP_ST_RESET;
      s.pins.addrOut <= 16'hffff;
      s.pins.readStrobeOut  <= 1'b1;
      s.pins.writeStrobeOut <= 1'b1;
      s.pins.byteEnableOut  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flip-flops
  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign dataOut        = s.pins.dataOut;
  assign dataOe         = s.pins.dataOe;
  assign addrOut        = s.pins.addrOut;
  assign addrOe         = s.pins.addrOe;
  assign readStrobeOut  = s.pins.readStrobeOut;
  assign readStrobeOe   = s.pins.readStrobeOe;
  assign writeStrobeOut = s.pins.writeStrobeOut;
  assign writeStrobeOe  = s.pins.writeStrobeOe;
  assign byteEnableOut  = s.pins.byteEnableOut;
  assign byteEnableOe   = s.pins.byteEnableOe;

endmodule : pport_control
`default_nettype wire

// ---- pport_defines.svh ----
// register offsets, field positions, reset values and masks of the parallel port
`ifndef PPORT_DEFINES_SVH
`define PPORT_DEFINES_SVH

// register byte offsets on the apb window
`define PP_OFF_CONTROL      8'h00
`define PP_OFF_MODE         8'h04
`define PP_OFF_ADDRESS      8'h08
`define PP_OFF_OUT_TWO      8'h0c
`define PP_OFF_IN_ONE       8'h10
`define PP_OFF_IN_TWO       8'h14
`define PP_OFF_PIN_ALLOC    8'h18
`define PP_OFF_STATUS       8'h1c

// port_control fields
`define PP_CTL_ENABLE       15
`define PP_CTL_IDLE_STOP    13
`define PP_CTL_MUX_HI       12
`define PP_CTL_MUX_LO       11
`define PP_CTL_BE_PIN_EN    10
`define PP_CTL_WR_PIN_EN    9
`define PP_CTL_RD_PIN_EN    8
`define PP_CTL_SEL_HI       7
`define PP_CTL_SEL_LO       6
`define PP_CTL_LATCH_POL    5
`define PP_CTL_SEL2_POL     4
`define PP_CTL_SEL1_POL     3
`define PP_CTL_BE_POL       2
`define PP_CTL_WR_POL       1
`define PP_CTL_RD_POL       0
`define PP_CTL_MASK         16'hbfff

// port_mode fields
`define PP_MODE_BUSY        15
`define PP_MODE_WIDE        10
`define PP_MODE_SEL_HI      9
`define PP_MODE_SEL_LO      8
`define PP_MODE_MASK        16'h7fff

// buffer_status_reg fields
`define PP_ST_IN_FULL       15
`define PP_ST_IN_OVF        14
`define PP_ST_IN0_FULL      8
`define PP_ST_OUT_EMPTY     7
`define PP_ST_OUT_UNF       6
`define PP_ST_OUT0_EMPTY    0
`define PP_ST_RESET         16'h008f

// field encodings
`define PP_MUX_NONE         2'h0
`define PP_MUX_FULL         2'h2
`define PP_SEL_BOTH         2'h2
`define PP_SEL_TWO          2'h1
`define PP_PM_MASTER1       2'h3

`endif

// ---- pport_pkg.sv ----
// types shared by the parallel port control logic
package pport_pkg;

  typedef enum logic [2:0] {
    PP_IDLE  = 3'h0,
    PP_ADDRL = 3'h1,
    PP_ADDRH = 3'h3,
    PP_STRB  = 3'h2,
    PP_HOLD  = 3'h6
  } pport_phase_t;

  typedef struct packed {
    logic [15:0] control;
    logic [15:0] mode;
    logic [15:0] address;
    logic [15:0] outTwo;
    logic [15:0] inOne;
    logic [15:0] inTwo;
    logic [15:0] pinAlloc;
    logic [15:0] status;
  } pport_regs_t;

  typedef struct packed {
    logic [7:0]  dataOut;
    logic        dataOe;
    logic [15:0] addrOut;
    logic [15:0] addrOe;
    logic        readStrobeOut;
    logic        readStrobeOe;
    logic        writeStrobeOut;
    logic        writeStrobeOe;
    logic        byteEnableOut;
    logic        byteEnableOe;
  } pport_pins_t;

  typedef struct packed {
    pport_regs_t  regs;
    pport_phase_t phase;
    logic         isRead;
    logic         slaveWrPrev;
    logic         slaveRdPrev;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    pport_pins_t  pins;
  } pport_state_t;

endpackage : pport_pkg

// ---- pport_control_properties.sv ----
// port-level assertions for the parallel port control block
`timescale 1ns/1ps
`default_nettype none
module pport_control_properties #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              rstn,
  // apb
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // pins
  input wire logic              idleMode,
  input wire logic [7:0]        dataOut,
  input wire logic              dataOe,
  input wire logic [15:0]       addrOe,
  input wire logic              writeStrobeOut,
  input wire logic              writeStrobeOe,
  input wire logic              readStrobeOe,
  input wire logic              byteEnableOe
);
  // shadow copies land on the same edge as the register write
  logic [15:0] ctl;
  logic [15:0] mode;
  logic [15:0] alloc;
  logic        done;
  logic        startWr;
  assign done = psel && penable && pready && pwrite && !pslverr;
  assign startWr = done && paddr == 8'h10 && ctl[15] && mode[9] && ctl[12:11] == 2'h0
                   && !(ctl[13] && idleMode);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl   <= 16'h0000;
      mode  <= 16'h0000;
      alloc <= 16'h0000;
    end else if (done) begin
      if (paddr == 8'h00) ctl <= pwdata[15:0] & 16'hbfff;
      if (paddr == 8'h04) mode <= pwdata[15:0] & 16'h7fff;
      if (paddr == 8'h18) alloc <= pwdata[15:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h1c |-> pslverr)
    else $error("no error on unmapped access");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_off_pins: assert property (!ctl[15] && !$past(ctl[15]) |-> addrOe == 16'h0000
    && !dataOe && !writeStrobeOe && !readStrobeOe && !byteEnableOe)
    else $error("pin driven while disabled");
  a_busy_off: assert property (pready && !pwrite && paddr == 8'h04 && !ctl[15]
    && !$past(ctl[15]) && !$past(ctl[15], 2) |-> !prdata[15])
    else $error("busy while disabled");
  a_write_walk: assert property (startWr |=> dataOe && dataOut == $past(pwdata[7:0])
    ##1 dataOe ##1 !dataOe)
    else $error("master write data phase wrong");
  a_strobe_level: assert property (startWr && mode[9:8] == 2'h2 && ctl[9]
    |=> writeStrobeOe && writeStrobeOut == ctl[1] ##1 writeStrobeOut != ctl[1])
    else $error("write strobe level wrong");
  a_strobe_off: assert property (!ctl[9] && !$past(ctl[9]) && !ctl[8] && !$past(ctl[8])
    |-> !writeStrobeOe && !readStrobeOe)
    else $error("strobe pin driven");
  a_alloc_pins: assert property (ctl[15] && mode[9] && $stable(ctl) && $stable(mode)
    && $stable(alloc) |=> addrOe == $past(alloc))
    else $error("address pins differ from allocation");
  c_master_write: cover property (startWr);
  c_unmapped: cover property (pready && pslverr);
  c_disabled_read: cover property (pready && !pwrite && paddr == 8'h04 && !ctl[15]);
endmodule : pport_control_properties
bind pport_control pport_control_properties #(.ADDR_W(ADDR_W)) u_props (
  .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .idleMode(idleMode), .dataOut(dataOut), .dataOe(dataOe), .addrOe(addrOe),
  .writeStrobeOut(writeStrobeOut), .writeStrobeOe(writeStrobeOe),
  .readStrobeOe(readStrobeOe), .byteEnableOe(byteEnableOe)
);
`default_nettype wire

// ---- pport_ext_device.sv ----
// behavioural external device on the far side of the port pins
`timescale 1ns/1ps
`default_nettype none
module pport_ext_device (
  // clock
  input  wire logic       clock,
  // pins driven by the port
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  input  wire logic       readStrobeOut,
  input  wire logic       readStrobeOe,
  input  wire logic       writeStrobeOut,
  input  wire logic       writeStrobeOe,
  // byte offered on a master read
  input  wire logic [7:0] readByte,
  // wire levels seen by the port
  output var  logic [7:0] dataIn,
  output var  logic       selectOneIn,
  output var  logic       writeStrobeIn,
  output var  logic       readStrobeIn
);
  logic [7:0] lastWritten = 8'h00;
  logic [7:0] lastLevel   = 8'h00;
  logic [7:0] slaveByte   = 8'h00;
  logic       slaveDrv    = 1'b0;
  initial begin
    selectOneIn   = 1'b0;
    writeStrobeIn = 1'b0;
    readStrobeIn  = 1'b0;
  end
  // released bus shows the inverse of its last level, never a stale copy
  always_comb begin
    if (slaveDrv) dataIn = slaveByte;
    else if (readStrobeOe && readStrobeOut) dataIn = readByte;
    else if (dataOe) dataIn = dataOut;
    else dataIn = ~lastLevel;
  end
  always @(posedge clock) begin
    lastLevel <= dataIn;
    if (writeStrobeOe && writeStrobeOut && dataOe) lastWritten <= dataOut;
  end
  // strobes are active high; data held one cycle past the strobe
  task automatic slave_write(input logic [7:0] value);
    @(posedge clock);
    slaveByte     <= value;
    slaveDrv      <= 1'b1;
    selectOneIn   <= 1'b1;
    writeStrobeIn <= 1'b1;
    repeat (2) @(posedge clock);
    writeStrobeIn <= 1'b0;
    selectOneIn   <= 1'b0;
    @(posedge clock);
    slaveDrv <= 1'b0;
  endtask : slave_write
endmodule : pport_ext_device
`default_nettype wire

// ---- pport_testbench.sv ----
// self-checking bench for the parallel port control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic [15:0] data;
    logic [15:0] mask;
    logic        err;
  } pport_note_t;
  logic        clock    = 1'b0;
  logic        rstn     = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = 32'h0;
  logic        idleMode = 1'b0;
  logic [7:0]  readByte = 8'h00;
  logic [31:0] prdata;
  logic        pready, pslverr, dataOe, selectOneIn;
  logic [7:0]  dataIn, dataOut, wByte, sByte;
  logic        readStrobeIn, readStrobeOut, readStrobeOe;
  logic        writeStrobeIn, writeStrobeOut, writeStrobeOe;
  logic [15:0] rnd;
  int unsigned seed;
  int          errors;
  int          checkCount;
  pport_note_t notes [$];
  pport_note_t note;
  logic [7:0]  rwOff  [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h14};
  logic [15:0] rwMask [6] = '{16'hbfff, 16'h7fff, 16'hffff, 16'hffff, 16'hffff, 16'h0000};
  always #50 clock = ~clock;
  pport_control u_dut (
    .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idleMode(idleMode), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .addrOut(), .addrOe(), .selectOneIn(selectOneIn), .readStrobeIn(readStrobeIn),
    .readStrobeOut(readStrobeOut), .readStrobeOe(readStrobeOe),
    .writeStrobeIn(writeStrobeIn), .writeStrobeOut(writeStrobeOut),
    .writeStrobeOe(writeStrobeOe), .byteEnableOut(), .byteEnableOe()
  );
  pport_ext_device u_dev (
    .clock(clock), .dataOut(dataOut), .dataOe(dataOe), .readStrobeOut(readStrobeOut),
    .readStrobeOe(readStrobeOe), .writeStrobeOut(writeStrobeOut),
    .writeStrobeOe(writeStrobeOe), .readByte(readByte), .dataIn(dataIn),
    .selectOneIn(selectOneIn), .writeStrobeIn(writeStrobeIn), .readStrobeIn(readStrobeIn)
  );
  task automatic fail(input string msg);
    errors++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask : fail
  task automatic check_data(input logic [15:0] got, input logic [15:0] exp,
                            input logic [15:0] mask);
    checkCount++;
    if ((got & mask) !== (exp & mask)) fail($sformatf("data %h expected %h", got, exp));
  endtask : check_data
  task automatic check_err(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) fail($sformatf("slave error %b expected %b", got, exp));
  endtask : check_err
  // notes the expectation, then holds the request until pready
  task automatic apb(input logic [7:0] addr, input logic wr, input logic [15:0] wdata,
                     input logic [15:0] expData, input logic [15:0] mask, input logic expErr);
    notes.push_back('{expData, mask, expErr});
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= addr;
    pwrite  <= wr;
    pwdata  <= {16'h0000, wdata};
    @(posedge clock);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    apb(addr, 1'b1, data, 16'h0000, 16'h0000, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    apb(addr, 1'b0, 16'h0000, exp, 16'hffff, 1'b0);
  endtask : rd
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    if (psel && penable && pready) begin
      if (notes.size() == 0) begin
        fail("answer with no note");
      end else begin
        note = notes.pop_front();
        check_data(prdata[15:0], note.data, note.mask);
        check_err(pslverr, note.err);
      end
    end
  end
  initial begin
    repeat (3000) @(posedge clock);
    fail("watchdog expired");
    finish_test();
  end
  initial begin
    seed = $urandom(33);
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), (i == 7) ? 16'h008f : 16'h0000);
    apb(8'h20, 1'b0, 16'h0000, 16'h0000, 16'hffff, 1'b1);
    apb(8'h40, 1'b1, 16'hffff, 16'h0000, 16'h0000, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rnd = 16'($urandom());
      wr(rwOff[i], rnd);
      rd(rwOff[i], rnd & rwMask[i]);
    end
    end_test("registers");
    wr(8'h00, 16'h0000);
    wr(8'h18, 16'hffff);
    wr(8'h04, 16'h0200);
    wr(8'h00, 16'h8303);
    wByte = 8'($urandom());
    readByte <= 8'($urandom());
    wr(8'h10, {8'h00, wByte});
    repeat (4) @(posedge clock);
    check_data({8'h00, u_dev.lastWritten}, {8'h00, wByte}, 16'h00ff);
    apb(8'h10, 1'b0, 16'h0000, {8'h00, wByte}, 16'h00ff, 1'b0);
    repeat (4) @(posedge clock);
    apb(8'h10, 1'b0, 16'h0000, {8'h00, readByte}, 16'h00ff, 1'b0);
    // master mode 1 with fully muxed address: enable strobe carries the write
    wr(8'h04, 16'h0300);
    wr(8'h00, 16'h9303);
    wr(8'h10, {8'h00, ~wByte});
    repeat (6) @(posedge clock);
    check_data({8'h00, u_dev.lastWritten}, {8'h00, ~wByte}, 16'h00ff);
    end_test("master");
    wr(8'h00, 16'hab03);
    idleMode <= 1'b1;
    wr(8'h10, {8'h00, wByte});
    repeat (4) @(posedge clock);
    check_data({8'h00, u_dev.lastWritten}, {8'h00, ~wByte}, 16'h00ff);
    rd(8'h04, 16'h0300);
    idleMode <= 1'b0;
    wr(8'h10, 16'h005a);
    // idle freezes the transfer in its address phase, so busy stands
    idleMode <= 1'b1;
    rd(8'h04, 16'h8300);
    wr(8'h00, 16'h0303);
    rd(8'h04, 16'h0300);
    idleMode <= 1'b0;
    rd(8'h10, 16'h005a);
    end_test("disable");
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h830b);
    sByte = 8'($urandom());
    u_dev.slave_write(sByte);
    rd(8'h1c, 16'h818f);
    wr(8'h00, 16'h030b);
    rd(8'h1c, 16'h818f);
    wr(8'h00, 16'h830b);
    rd(8'h1c, 16'h008f);
    apb(8'h10, 1'b0, 16'h0000, {8'h00, sByte}, 16'h00ff, 1'b0);
    end_test("slave");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
